// [optical_status_pkg.sv]
// constants and register map for the optical module status register bank
// Functional notes
// - sixteen words per lane register type
// - lane fault word bits 14,13,7,6,4,3,2
// - module temperature flags bits 11..8, 15..12 zero
// - supply voltage flags bits 7..4
// - amplifier bias flags bits 3..0
// - general status bit 13 cooling overload
// - any fault status bit forces module state Fault; lane fault bits do not
// - fault bits only for fatal faults
// - fault bits 6 init, 5 supply, 1 checksum
// - bias word unsigned, 2 uA step
// - coherent application code in normal mode: bias 100 uA step
// - coherent mode tx power signed 0.01 dBm
// - normal mode tx power unsigned 0.1 uW
// - laser temperature signed 1/256 degree
// - rx power 0.1 uW, average or amplitude
// - per-lane enable word, reset all ones
package optical_status_pkg;
  localparam int NUM_LANES = 16;
  localparam int LANE_BITS = 4;
  localparam logic [15:0] GEN_STATUS_NORMAL = 16'ha01d;
  localparam logic [15:0] FAULT_STATUS_NORMAL = 16'ha01e;
  localparam logic [15:0] LANE_FAULT_NORMAL = 16'ha210;
  localparam logic [15:0] BIAS_MON_NORMAL = 16'ha2a0;
  localparam logic [15:0] TXPWR_MON_NORMAL = 16'ha2b0;
  localparam logic [15:0] TEMP_MON_NORMAL = 16'ha2c0;
  localparam logic [15:0] RXPWR_MON_NORMAL = 16'ha2d0;
  localparam logic [15:0] GEN_STATUS_COHERENT = 16'hb01d;
  localparam logic [15:0] FAULT_STATUS_COHERENT = 16'hb01e;
  localparam logic [15:0] ALARM_WARN_FLAGS = 16'hb01f;
  localparam logic [15:0] LANE_AW_ENABLE_COHERENT = 16'hb1e0;
  localparam logic [15:0] BIAS_MON_COHERENT = 16'hb320;
  localparam logic [15:0] TXPWR_MON_COHERENT = 16'hb330;
  localparam logic [15:0] TEMP_MON_COHERENT = 16'hb340;
  localparam logic [15:0] RXPWR_MON_COHERENT = 16'hb350;
  localparam logic [15:0] LANE_AW_ENABLE_RESET = 16'hffff;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [15:0] LANE_FAULT_MASK = 16'h60dc;
  localparam logic [15:0] FAULT_STATUS_MASK = 16'h0062;
  localparam int COOLING_BIT = 13;
  localparam int FAULT_INIT_BIT = 6;
  localparam int FAULT_SUPPLY_BIT = 5;
  localparam int FAULT_CHECKSUM_BIT = 1;
  localparam int TEMP_FLAG_LSB = 8;
  localparam int VCC_FLAG_LSB = 4;
  localparam int AMP_FLAG_LSB = 0;
  localparam int BIAS_COHERENT_DIV = 50;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_FAULT = 2'b01
  } module_state_e;
endpackage

// [lane_status_word.sv]
// one lane: packs fault bits and registers monitor words
`timescale 1ns/1ps
`default_nettype none
module lane_status_word
  import optical_status_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // lane sources
  input wire logic wavelength_unlocked,
  input wire logic avalanche_photodiode_fault,
  input wire logic tx_loss_of_function,
  input wire logic tx_loss_of_lock,
  input wire logic rx_loss_of_signal,
  input wire logic rx_loss_of_lock,
  input wire logic rx_fifo_error,
  input wire logic [15:0] bias_raw_2ua,
  input wire logic [15:0] tx_power_raw,
  input wire logic [15:0] laser_temp_raw,
  input wire logic [15:0] rx_power_raw,
  input wire logic bias_coarse,
  // registered words
  output logic [15:0] fault_word_r,
  output logic [15:0] bias_r,
  output logic [15:0] txpwr_r,
  output logic [15:0] temp_r,
  output logic [15:0] rxpwr_r
);
  logic [15:0] fault_nxt;
  logic [15:0] bias_nxt;

  always_comb begin
    fault_nxt = ZERO_WORD;
    fault_nxt[14] = wavelength_unlocked;
    fault_nxt[13] = avalanche_photodiode_fault;
    fault_nxt[7] = tx_loss_of_function;
    fault_nxt[6] = tx_loss_of_lock;
    fault_nxt[4] = rx_loss_of_signal;
    fault_nxt[3] = rx_loss_of_lock;
    fault_nxt[2] = rx_fifo_error;
  end

  // source counts in 2 uA; 100 uA step divides by fifty
  always_comb begin
    if (bias_coarse) begin
      bias_nxt = 16'(bias_raw_2ua / 16'(BIAS_COHERENT_DIV));
    end else begin
      bias_nxt = bias_raw_2ua;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fault_word_r <= ZERO_WORD;
      bias_r <= ZERO_WORD;
      txpwr_r <= ZERO_WORD;
      temp_r <= ZERO_WORD;
      rxpwr_r <= ZERO_WORD;
    end else begin
      fault_word_r <= fault_nxt & LANE_FAULT_MASK;
      bias_r <= bias_nxt;
      txpwr_r <= tx_power_raw;
      temp_r <= laser_temp_raw;
      rxpwr_r <= rx_power_raw;
    end
  end
endmodule
`default_nettype wire

// [optical_module_status_regs.sv]
// status and monitor register bank of an optical module
`timescale 1ns/1ps
`default_nettype none
module optical_module_status_regs
  import optical_status_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // management register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // module configuration
  input wire logic coherent_optics_mode,
  input wire logic coherent_application,
  input wire logic modulation_amplitude,
  // module level sources
  input wire logic [3:0] temp_flags,
  input wire logic [3:0] vcc_flags,
  input wire logic [3:0] optical_amplifier_flags,
  input wire logic cooling_overload_flag,
  input wire logic init_fault,
  input wire logic supply_fault,
  input wire logic checksum_fault,
  // lane sources, one bit or word per lane
  input wire logic [NUM_LANES-1:0] wavelength_unlocked,
  input wire logic [NUM_LANES-1:0] avalanche_photodiode_fault,
  input wire logic [NUM_LANES-1:0] tx_loss_of_function,
  input wire logic [NUM_LANES-1:0] tx_loss_of_lock,
  input wire logic [NUM_LANES-1:0] rx_loss_of_signal,
  input wire logic [NUM_LANES-1:0] rx_loss_of_lock,
  input wire logic [NUM_LANES-1:0] rx_fifo_error,
  input wire logic [NUM_LANES*16-1:0] bias_raw_2ua,
  input wire logic [NUM_LANES*16-1:0] tx_power_raw,
  input wire logic [NUM_LANES*16-1:0] laser_temp_raw,
  input wire logic [NUM_LANES*16-1:0] rx_power_raw,
  // outputs to the rest of the module
  output logic module_fault,
  output logic rx_power_is_amplitude,
  output logic [NUM_LANES*16-1:0] lane_alarm_enable
);
  logic [15:0] fault_word [NUM_LANES];
  logic [15:0] bias_word [NUM_LANES];
  logic [15:0] txpwr_word [NUM_LANES];
  logic [15:0] temp_word [NUM_LANES];
  logic [15:0] rxpwr_word [NUM_LANES];
  logic [15:0] aw_enable_r [NUM_LANES];
  logic [15:0] alarm_flags_r;
  logic [15:0] gen_status_r;
  logic [15:0] fatal_status_r;
  logic [15:0] fatal_nxt;
  logic [15:0] rdata_nxt;
  logic [15:0] lane_word [NUM_LANES];
  logic [15:0] page_base;
  logic [LANE_BITS-1:0] lane_idx;
  logic page_lane_fault;
  logic page_bias;
  logic page_txpwr;
  logic page_temp;
  logic page_rxpwr;
  logic page_aw_enable;
  logic page_any;
  logic aw_wr;
  logic bias_coarse;
  logic any_fatal;
  module_state_e state_r;
  module_state_e state_nxt;

  assign lane_idx = reg_addr[LANE_BITS-1:0];
  // lane arrays occupy sixteen consecutive words from a page base
  assign page_base = {reg_addr[15:LANE_BITS], {LANE_BITS{1'b0}}};
  assign page_lane_fault = (page_base == LANE_FAULT_NORMAL);
  assign page_bias = (page_base == BIAS_MON_NORMAL) || (page_base == BIAS_MON_COHERENT);
  assign page_txpwr = (page_base == TXPWR_MON_NORMAL) || (page_base == TXPWR_MON_COHERENT);
  assign page_temp = (page_base == TEMP_MON_NORMAL) || (page_base == TEMP_MON_COHERENT);
  assign page_rxpwr = (page_base == RXPWR_MON_NORMAL) || (page_base == RXPWR_MON_COHERENT);
  assign page_aw_enable = (page_base == LANE_AW_ENABLE_COHERENT);
  assign page_any = page_lane_fault | page_bias | page_txpwr | page_temp | page_rxpwr
    | page_aw_enable;
  // the only writable words; every other write is dropped
  assign aw_wr = reg_wr & page_aw_enable;
  // coarse bias only when normal map reports a coherent application
  assign bias_coarse = coherent_application & ~coherent_optics_mode;
  assign rx_power_is_amplitude = modulation_amplitude;
  assign module_fault = (state_r == ST_FAULT);

  genvar g;
  generate
    for (g = 0; g < NUM_LANES; g++) begin : lane_g
      lane_status_word u_lane (
        .mclk(mclk),
        .rst_n(rst_n),
        .wavelength_unlocked(wavelength_unlocked[g]),
        .avalanche_photodiode_fault(avalanche_photodiode_fault[g]),
        .tx_loss_of_function(tx_loss_of_function[g]),
        .tx_loss_of_lock(tx_loss_of_lock[g]),
        .rx_loss_of_signal(rx_loss_of_signal[g]),
        .rx_loss_of_lock(rx_loss_of_lock[g]),
        .rx_fifo_error(rx_fifo_error[g]),
        .bias_raw_2ua(bias_raw_2ua[g*16 +: 16]),
        .tx_power_raw(tx_power_raw[g*16 +: 16]),
        .laser_temp_raw(laser_temp_raw[g*16 +: 16]),
        .rx_power_raw(rx_power_raw[g*16 +: 16]),
        .bias_coarse(bias_coarse),
        .fault_word_r(fault_word[g]),
        .bias_r(bias_word[g]),
        .txpwr_r(txpwr_word[g]),
        .temp_r(temp_word[g]),
        .rxpwr_r(rxpwr_word[g])
      );

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          aw_enable_r[g] <= LANE_AW_ENABLE_RESET;
        end else if (aw_wr && (lane_idx == LANE_BITS'(g))) begin
          aw_enable_r[g] <= reg_wdata;
        end
      end
      assign lane_alarm_enable[g*16 +: 16] = aw_enable_r[g];

      // pick the page word per lane, so the lane select is a single mux
      always_comb begin
        lane_word[g] = ZERO_WORD;
        if (page_lane_fault) begin
          lane_word[g] = fault_word[g];
        end else if (page_bias) begin
          lane_word[g] = bias_word[g];
        end else if (page_txpwr) begin
          lane_word[g] = txpwr_word[g];
        end else if (page_temp) begin
          lane_word[g] = temp_word[g];
        end else if (page_rxpwr) begin
          lane_word[g] = rxpwr_word[g];
        end else if (page_aw_enable) begin
          lane_word[g] = aw_enable_r[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_flags_r <= ZERO_WORD;
    end else begin
      alarm_flags_r <= ZERO_WORD;
      alarm_flags_r[TEMP_FLAG_LSB +: 4] <= temp_flags;
      alarm_flags_r[VCC_FLAG_LSB +: 4] <= vcc_flags;
      alarm_flags_r[AMP_FLAG_LSB +: 4] <= optical_amplifier_flags;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gen_status_r <= ZERO_WORD;
    end else begin
      gen_status_r <= ZERO_WORD;
      gen_status_r[COOLING_BIT] <= cooling_overload_flag;
    end
  end

  // only fatal sources are wired here; lesser conditions have no path in
  always_comb begin
    fatal_nxt = ZERO_WORD;
    fatal_nxt[FAULT_INIT_BIT] = init_fault;
    fatal_nxt[FAULT_SUPPLY_BIT] = supply_fault;
    fatal_nxt[FAULT_CHECKSUM_BIT] = checksum_fault;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fatal_status_r <= ZERO_WORD;
    end else begin
      fatal_status_r <= fatal_nxt & FAULT_STATUS_MASK;
    end
  end

  // module state follows the fault word; recovery is the state machine's concern
  assign any_fatal = |fatal_status_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (any_fatal) begin
          state_nxt = ST_FAULT;
        end
      end
      ST_FAULT: begin
        if (!any_fatal) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // read decode; lane arrays occupy sixteen consecutive words
  always_comb begin
    rdata_nxt = ZERO_WORD;
    case (reg_addr)
      GEN_STATUS_NORMAL, GEN_STATUS_COHERENT: begin
        rdata_nxt = gen_status_r;
      end
      FAULT_STATUS_NORMAL, FAULT_STATUS_COHERENT: begin
        rdata_nxt = fatal_status_r;
      end
      ALARM_WARN_FLAGS: begin
        rdata_nxt = alarm_flags_r;
      end
      default: begin
        // unmapped pages keep the zero word
        if (page_any) begin
          rdata_nxt = lane_word[lane_idx];
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // data stands until the next read, so a slow master can still take it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= ZERO_WORD;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end
endmodule
`default_nettype wire

// [optical_status_props.sv]
// port checker for the status register bank
`timescale 1ns/1ps
`default_nettype none
module optical_status_props
  import optical_status_pkg::*;
(
  // watched ports
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic modulation_amplitude,
  input wire logic init_fault,
  input wire logic supply_fault,
  input wire logic checksum_fault,
  input wire logic module_fault,
  input wire logic rx_power_is_amplitude,
  input wire logic [NUM_LANES*16-1:0] lane_alarm_enable
);
  logic any_fault, wr_hit;
  logic [3:0] wl_r;
  logic [15:0] wd_r;
  assign any_fault = init_fault | supply_fault | checksum_fault;
  assign wr_hit = reg_wr && (reg_addr[15:4] == LANE_AW_ENABLE_COHERENT[15:4]);
  // no reset needed: only looked at one cycle after a taken write
  always_ff @(posedge mclk) begin
    wl_r <= reg_addr[3:0];
    wd_r <= reg_wdata;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence fault_held; any_fault [*3]; endsequence
  sequence fault_gone; !any_fault [*3]; endsequence
  a_read_answered: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_answer_has_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved");
  a_fault_state_entry: assert property (fault_held |-> module_fault)
    else $error("fault state missed");
  a_fault_state_exit: assert property (fault_gone |-> !module_fault)
    else $error("fault state without fault");
  a_amplitude_follows: assert property (rx_power_is_amplitude == modulation_amplitude)
    else $error("amplitude select wrong");
  a_enable_write_lands: assert property (wr_hit |=> lane_alarm_enable[wl_r*16 +: 16] == wd_r)
    else $error("enable write lost");
  a_enable_quiet: assert property (!wr_hit |=> $stable(lane_alarm_enable))
    else $error("enable changed");
endmodule
bind optical_module_status_regs optical_status_props i_props (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .modulation_amplitude(modulation_amplitude), .init_fault(init_fault),
  .supply_fault(supply_fault), .checksum_fault(checksum_fault), .module_fault(module_fault),
  .rx_power_is_amplitude(rx_power_is_amplitude), .lane_alarm_enable(lane_alarm_enable)
);
`default_nettype wire

// [mgmt_host.sv]
// management master model for the register port
`timescale 1ns/1ps
`default_nettype none
module mgmt_host (
  // clock
  input wire logic mclk,
  // register port
  output logic [15:0] reg_addr = 16'h0000,
  output logic reg_rd = 1'b0,
  output logic reg_wr = 1'b0,
  output logic [15:0] reg_wdata = 16'h0000,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  // board control: a non-pluggable host holds this high through initialization
  output logic programmable_control_pin_three = 1'b1
);
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    // stale data is not left looking valid
    reg_wdata = ~d;
  endtask
  // bounded wait: a lost answer must not hang the run
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    ok = 1'b0;
    d = 16'h0000;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata;
      end else begin
        @(negedge mclk);
      end
    end
  endtask
endmodule
`default_nettype wire

// [optical_module_status_regs_tb.sv]
// bench for the status register bank, driven through the host model
`timescale 1ns/1ps
`default_nettype none
module optical_module_status_regs_tb
  import optical_status_pkg::*;
;
  logic mclk = 1'b0, rst_n = 1'b0, ok;
  logic reg_rd, reg_wr, reg_rvalid, module_fault, rx_power_is_amplitude;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, rd_data;
  logic coherent_optics_mode, coherent_application, modulation_amplitude, cooling_overload_flag;
  logic init_fault, supply_fault, checksum_fault, programmable_control_pin_three;
  logic [3:0] temp_flags, vcc_flags, optical_amplifier_flags;
  logic [NUM_LANES-1:0] wavelength_unlocked, avalanche_photodiode_fault, tx_loss_of_function;
  logic [NUM_LANES-1:0] tx_loss_of_lock, rx_loss_of_signal, rx_loss_of_lock, rx_fifo_error;
  logic [NUM_LANES*16-1:0] bias_raw_2ua, tx_power_raw, laser_temp_raw, rx_power_raw;
  logic [NUM_LANES*16-1:0] lane_alarm_enable;
  logic [15:0] lf_exp [8] = '{16'h4000, 16'h2000, 16'h0080, 16'h0040,
    16'h0010, 16'h0008, 16'h0004, 16'h0000};
  logic [15:0] fexp [3] = '{16'h0040, 16'h0020, 16'h0002};
  int n_errors = 0, compares = 0;
  always #10 mclk = ~mclk;
  optical_module_status_regs i_dut (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .coherent_optics_mode(coherent_optics_mode), .coherent_application(coherent_application),
    .modulation_amplitude(modulation_amplitude), .temp_flags(temp_flags),
    .vcc_flags(vcc_flags), .optical_amplifier_flags(optical_amplifier_flags),
    .cooling_overload_flag(cooling_overload_flag), .init_fault(init_fault),
    .supply_fault(supply_fault), .checksum_fault(checksum_fault),
    .wavelength_unlocked(wavelength_unlocked),
    .avalanche_photodiode_fault(avalanche_photodiode_fault),
    .tx_loss_of_function(tx_loss_of_function), .tx_loss_of_lock(tx_loss_of_lock),
    .rx_loss_of_signal(rx_loss_of_signal), .rx_loss_of_lock(rx_loss_of_lock),
    .rx_fifo_error(rx_fifo_error), .bias_raw_2ua(bias_raw_2ua), .tx_power_raw(tx_power_raw),
    .laser_temp_raw(laser_temp_raw), .rx_power_raw(rx_power_raw),
    .module_fault(module_fault), .rx_power_is_amplitude(rx_power_is_amplitude),
    .lane_alarm_enable(lane_alarm_enable)
  );
  mgmt_host i_host (
    .mclk(mclk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .programmable_control_pin_three(programmable_control_pin_three)
  );
  task automatic wrap_up();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [15:0] e);
    i_host.rd(a, rd_data, ok);
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR answer at %h expected 1 seen 0", a);
      wrap_up();
    end else begin
      chk($sformatf("word %h", a), e, rd_data);
    end
  endtask
  initial begin
    {coherent_optics_mode, coherent_application, modulation_amplitude, cooling_overload_flag} = '0;
    {init_fault, supply_fault, checksum_fault, temp_flags, vcc_flags, optical_amplifier_flags} = '0;
    {wavelength_unlocked, avalanche_photodiode_fault, tx_loss_of_function, tx_loss_of_lock} = '0;
    {rx_loss_of_signal, rx_loss_of_lock, rx_fifo_error} = '0;
    {bias_raw_2ua, tx_power_raw, laser_temp_raw, rx_power_raw} = '0;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    chk("control pin three", 16'h0001, {15'h0000, programmable_control_pin_three});
    rchk(FAULT_STATUS_COHERENT, 16'h0000);
    rchk(LANE_AW_ENABLE_COHERENT + 16'h000f, LANE_AW_ENABLE_RESET);
    // one source per lane shows both bit placement and lane separation
    wavelength_unlocked = 16'h0001;
    avalanche_photodiode_fault = 16'h0002;
    tx_loss_of_function = 16'h0004;
    tx_loss_of_lock = 16'h0008;
    rx_loss_of_signal = 16'h0010;
    rx_loss_of_lock = 16'h0020;
    rx_fifo_error = 16'h0040;
    for (int i = 0; i < 8; i++) rchk(LANE_FAULT_NORMAL + 16'(i), lf_exp[i]);
    {wavelength_unlocked, avalanche_photodiode_fault, tx_loss_of_function, tx_loss_of_lock} = '1;
    {rx_loss_of_signal, rx_loss_of_lock, rx_fifo_error} = '1;
    rchk(LANE_FAULT_NORMAL + 16'h000f, LANE_FAULT_MASK);
    temp_flags = 4'ha;
    vcc_flags = 4'h5;
    optical_amplifier_flags = 4'h9;
    rchk(ALARM_WARN_FLAGS, 16'h0a59);
    {temp_flags, vcc_flags, optical_amplifier_flags} = 12'h5a6;
    rchk(ALARM_WARN_FLAGS, 16'h05a6);
    cooling_overload_flag = 1'b1;
    rchk(GEN_STATUS_NORMAL, 16'h2000);
    rchk(GEN_STATUS_COHERENT, 16'h2000);
    chk("module_fault", 16'h0000, {15'h0000, module_fault});
    for (int k = 0; k < 3; k++) begin
      {init_fault, supply_fault, checksum_fault} = 3'b100 >> k;
      rchk(FAULT_STATUS_NORMAL, fexp[k]);
      chk("module_fault", 16'h0001, {15'h0000, module_fault});
    end
    i_host.wr(FAULT_STATUS_NORMAL, 16'hffff);
    rchk(FAULT_STATUS_NORMAL, 16'h0002);
    {init_fault, supply_fault, checksum_fault} = 3'b000;
    repeat (3) @(negedge mclk);
    chk("module_fault", 16'h0000, {15'h0000, module_fault});
    bias_raw_2ua[47:32] = 16'h1388;
    tx_power_raw[47:32] = 16'hff38;
    laser_temp_raw[47:32] = 16'he700;
    rx_power_raw[47:32] = 16'h1234;
    rchk(BIAS_MON_NORMAL + 16'h0002, 16'h1388);
    rchk(TXPWR_MON_NORMAL + 16'h0002, 16'hff38);
    rchk(TEMP_MON_NORMAL + 16'h0002, 16'he700);
    rchk(RXPWR_MON_NORMAL + 16'h0002, 16'h1234);
    coherent_application = 1'b1;
    modulation_amplitude = 1'b1;
    rchk(BIAS_MON_NORMAL + 16'h0002, 16'h0064);
    chk("amplitude", 16'h0001, {15'h0000, rx_power_is_amplitude});
    coherent_optics_mode = 1'b1;
    rchk(BIAS_MON_COHERENT + 16'h0002, 16'h1388);
    rchk(RXPWR_MON_COHERENT + 16'h0002, 16'h1234);
    rchk(TXPWR_MON_COHERENT + 16'h0002, 16'hff38);
    rchk(TEMP_MON_COHERENT + 16'h0002, 16'he700);
    i_host.wr(16'hb1e3, 16'h1234);
    i_host.wr(16'hb1ef, 16'h0000);
    i_host.wr(16'hb1f0, 16'h5555);
    rchk(16'hb1e3, 16'h1234);
    rchk(16'hb1ef, 16'h0000);
    rchk(16'hb1e4, 16'hffff);
    rchk(16'hb1f0, 16'h0000);
    chk("enable lane 3", 16'h1234, lane_alarm_enable[63:48]);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    rchk(16'hb1e3, LANE_AW_ENABLE_RESET);
    wrap_up();
  end
endmodule
`default_nettype wire
